// [verilog/pxb_crossbar.sv]
`timescale 1ns/1ps
`include "pxb_regs.svh"
// What this block does
// - twenty-four pins in three byte ports; gpio or routed.
// - each port latch always shows the synchronised pin level.
// - functions are placed in one fixed priority order, serial first.
// - each non-serial function takes the lowest free pin, port 0 first.
// - serial transmit and receive sit fixed on pins 0.4 and 0.5.
// - a pin given to a higher function is passed over later.
// - a pin with its exclude bit set counts as occupied.
// - one eight-bit exclude mask per port, bit n is pin n.
// - oscillator, reference, convert start, dac pins are skipped only when their exclude bits are set.
// - a per-pin drive bit picks push-pull or open-drain.
// - two select bytes choose functions; unselected ones take no pin.
// - slave select is routed only in 4-wire spi mode.
// - i2c enable claims data and clock; serial claims both lines.
// - with enable clear every pin is an input, drivers off.
// - leftover pins are ordinary port i/o.
module pxb_crossbar
  import pxb_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  input  wire pxb_sel_s          sel,
  input  wire pxb_pincfg_s       pincfg,
  input  wire logic [23:0]       port_latch_out,
  input  wire logic [21:0]       func_out,
  input  wire logic [21:0]       func_idle,
  input  wire logic [23:0]       pin_in,
  output logic      [23:0]       pin_out,
  output logic      [23:0]       pin_oe,
  output logic      [23:0]       port_latch_in,
  output logic      [21:0]       func_in,
  output logic      [21:0]       func_placed
);
  // ----------------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------------
  logic [23:0] pin_meta;
  logic [23:0] pin_sync;
  // pins are asynchronous; only pin_sync is read past this point

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= `PXB_RESET_PINS;
      pin_sync <= `PXB_RESET_PINS;
    end else if (clk_en) begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------------
  // requests
  // ----------------------------------------------------------------------
  logic [21:0] req;
  logic        enable;

  assign enable = sel.sel_high[`PXB_SH_EN];

  always_comb begin
    req = '0;
    req[`PXB_F_TX]   = sel.sel_low[`PXB_SL_SER];
    req[`PXB_F_RX]   = sel.sel_low[`PXB_SL_SER];
    req[`PXB_F_SCK]  = sel.sel_low[`PXB_SL_SPI];
    req[`PXB_F_MISO] = sel.sel_low[`PXB_SL_SPI];
    req[`PXB_F_MOSI] = sel.sel_low[`PXB_SL_SPI];
    req[`PXB_F_NSS]  = sel.sel_low[`PXB_SL_SPI] &
                       sel.ss_mode[`PXB_SS_4WIRE_BIT];
    req[`PXB_F_SDA]  = sel.sel_low[`PXB_SL_I2C];
    req[`PXB_F_SCL]  = sel.sel_low[`PXB_SL_I2C];
    req[`PXB_F_CPA]  = sel.sel_low[`PXB_SL_CPA];
    req[`PXB_F_CPAA] = sel.sel_low[`PXB_SL_CPAA];
    req[`PXB_F_CPB]  = sel.sel_low[`PXB_SL_CPB];
    req[`PXB_F_CPBA] = sel.sel_low[`PXB_SL_CPBA];
    req[`PXB_F_SYSTEM_CLOCK_OUTPUT] = sel.sel_low[`PXB_SL_SYSTEM_CLOCK_OUTPUT];
    // capture outputs: three-bit count of modules routed
    for (int c = 0; c < 6; c++) begin
      req[`PXB_F_CAPTURE_COMPARE_OUT_ZERO + c] =
        (32'(sel.sel_high[`PXB_SH_CEX_LSB +: 3]) > c);
    end
    req[`PXB_F_ECI] = sel.sel_high[`PXB_SH_ECI];
    req[`PXB_F_T0]  = sel.sel_high[`PXB_SH_T0];
    req[`PXB_F_T1]  = sel.sel_high[`PXB_SH_T1];
  end

  // ----------------------------------------------------------------------
  // priority decode; special-function pins only leave via exclude mask
  // ----------------------------------------------------------------------
  pxb_fn_t     next_route [`PXB_NPINS];
  logic [23:0] taken;
  logic [21:0] next_placed;
  logic        found;

  always_comb begin
    // an excluded pin is simply pre-taken, so skips and claims share a path
    taken       = pincfg.mask;
    next_placed = '0;
    found       = 1'b0;
    for (int p = 0; p < `PXB_NPINS; p++) begin
      next_route[p] = `PXB_F_NONE;
    end
    // the serial pair overrides the mask so the fixed pins never move
    if (req[`PXB_F_TX]) begin
      next_route[`PXB_TX_PIN] = 5'(`PXB_F_TX);
      next_route[`PXB_RX_PIN] = 5'(`PXB_F_RX);
      taken[`PXB_TX_PIN]      = 1'b1;
      taken[`PXB_RX_PIN]      = 1'b1;
      next_placed[`PXB_F_TX]  = 1'b1;
      next_placed[`PXB_F_RX]  = 1'b1;
    end
    for (int f = `PXB_F_SCK; f <= `PXB_F_T1; f++) begin
      found = 1'b0;
      for (int p = 0; p < `PXB_NPINS; p++) begin
        if (req[f] && !found && !taken[p]) begin
          found          = 1'b1;
          taken[p]       = 1'b1;
          next_route[p]  = 5'(f);
          next_placed[f] = 1'b1;
        end
      end
    end
    if (!enable) begin
      for (int p = 0; p < `PXB_NPINS; p++) begin
        next_route[p] = `PXB_F_NONE;
      end
      next_placed = '0;
    end
  end

  // ----------------------------------------------------------------------
  // registered routing, refreshed every enabled cycle
  // ----------------------------------------------------------------------
  pxb_fn_t route [`PXB_NPINS];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < `PXB_NPINS; p++) begin
        route[p] <= `PXB_F_NONE;
      end
      func_placed <= '0;
    end else if (clk_en) begin
      for (int p = 0; p < `PXB_NPINS; p++) begin
        route[p] <= next_route[p];
      end
      func_placed <= next_placed;
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers; i2c lines are always open-drain
  // ----------------------------------------------------------------------
  logic [23:0] next_out;
  logic [23:0] next_oe;
  logic        lvl;

  always_comb begin
    next_out = '0;
    next_oe  = '0;
    lvl      = 1'b0;
    for (int p = 0; p < `PXB_NPINS; p++) begin
      if (next_route[p] == `PXB_F_NONE) begin
        lvl = port_latch_out[p];
      end else begin
        lvl = func_out[next_route[p]];
      end
      if (enable) begin
        if (pincfg.drive_pp[p] && next_route[p] != 5'(`PXB_F_SDA) &&
            next_route[p] != 5'(`PXB_F_SCL)) begin
          next_out[p] = lvl;
          next_oe[p]  = 1'b1;
        end else begin
          // open-drain: release for a one, pull low for a zero
          next_out[p] = 1'b0;
          next_oe[p]  = !lvl;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= `PXB_RESET_PINS;
      pin_oe  <= `PXB_RESET_PINS;
    end else if (clk_en) begin
      // drivers follow next_route so pins and placement move together
      pin_out <= next_out;
      pin_oe  <= next_oe;
    end
  end

  // ----------------------------------------------------------------------
  // inputs to functions and port latch read-back
  // ----------------------------------------------------------------------
  // limitation: a routed input trails its pin by sync plus one route cycle
  logic [21:0] next_fin;

  always_comb begin
    next_fin = func_idle;
    for (int p = 0; p < `PXB_NPINS; p++) begin
      if (route[p] != `PXB_F_NONE) begin
        next_fin[route[p]] = pin_sync[p];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      func_in       <= '0;
      port_latch_in <= `PXB_RESET_PINS;
    end else if (clk_en) begin
      func_in       <= next_fin;
      port_latch_in <= pin_sync;
    end
  end
endmodule // pxb_crossbar

// [verilog/pxb_regs.svh]
`ifndef PXB_REGS_SVH
`define PXB_REGS_SVH
// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define PXB_NPINS        24
`define PXB_NFUNC        23
// ----------------------------------------------------------------------
// fixed serial pins (port 0 index)
// ----------------------------------------------------------------------
`define PXB_TX_PIN       5'h04
`define PXB_RX_PIN       5'h05
// ----------------------------------------------------------------------
// function index in priority order
// ----------------------------------------------------------------------
`define PXB_F_TX         0
`define PXB_F_RX         1
`define PXB_F_SCK        2
`define PXB_F_MISO       3
`define PXB_F_MOSI       4
`define PXB_F_NSS        5
`define PXB_F_SDA        6
`define PXB_F_SCL        7
`define PXB_F_CPA        8
`define PXB_F_CPAA       9
`define PXB_F_CPB        10
`define PXB_F_CPBA       11
`define PXB_F_SYSTEM_CLOCK_OUTPUT     12
`define PXB_F_CAPTURE_COMPARE_OUT_ZERO       13
`define PXB_F_ECI        19
`define PXB_F_T0         20
`define PXB_F_T1         21
`define PXB_F_NONE       5'h1f
// ----------------------------------------------------------------------
// select low bit positions
// ----------------------------------------------------------------------
`define PXB_SL_SER       0
`define PXB_SL_SPI       1
`define PXB_SL_I2C       2
`define PXB_SL_SYSTEM_CLOCK_OUTPUT    3
`define PXB_SL_CPA       4
`define PXB_SL_CPAA      5
`define PXB_SL_CPB       6
`define PXB_SL_CPBA      7
// ----------------------------------------------------------------------
// select high bit positions
// ----------------------------------------------------------------------
`define PXB_SH_CEX_LSB   0
`define PXB_SH_ECI       3
`define PXB_SH_T0        4
`define PXB_SH_T1        5
`define PXB_SH_EN        6
// ----------------------------------------------------------------------
// slave select mode, 4-wire codes have msb set
// ----------------------------------------------------------------------
`define PXB_SS_4WIRE_BIT 1
`define PXB_RESET_BYTE   8'h00
`define PXB_RESET_PINS   24'h00_0000
`endif

// [verilog/pxb_pkg.sv]
package pxb_pkg;
  // per-pin route code: function index, or none for port i/o
  typedef logic [4:0] pxb_fn_t;
  typedef struct packed {
    logic [23:0] mask;
    logic [23:0] drive_pp;
  } pxb_pincfg_s;
  typedef struct packed {
    logic [7:0] sel_low;
    logic [7:0] sel_high;
    logic [1:0] ss_mode;
  } pxb_sel_s;
endpackage

// [sim/pxb_pin_model.sv]
`timescale 1ns/1ps
module pxb_pin_model (
  input  wire logic [23:0] pin_out,
  input  wire logic [23:0] pin_oe,
  input  wire logic [23:0] board,
  output logic      [23:0] pin_in
);
  // a released pin shows the board level; board idles high for the pull-up
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : board[i];
    end
  end
endmodule // pxb_pin_model

// [sim/pxb_crossbar_properties.sv]
`timescale 1ns/1ps
module pxb_crossbar_properties
  import pxb_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        clk_en,
  input wire pxb_sel_s    sel,
  input wire pxb_pincfg_s pincfg,
  input wire logic [21:0] func_out,
  input wire logic [21:0] func_idle,
  input wire logic [23:0] pin_in,
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] port_latch_in,
  input wire logic [21:0] func_in,
  input wire logic [21:0] func_placed
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic en;
  assign en = sel.sel_high[6];
  AST_OFF: assert property (clk_en && !en |=>
    pin_oe == '0 && func_placed == '0) else $error("drivers on while off");
  AST_SER: assert property (
    clk_en && en && sel.sel_low[0] && pincfg.drive_pp[4] |=>
    func_placed[1:0] == 2'b11 && pin_oe[4] && pin_out[4] == $past(func_out[0]))
    else $error("serial pair not fixed");
  AST_NOSEL: assert property (
    clk_en && en && !sel.sel_low[0] |=> func_placed[1:0] == 2'b00)
    else $error("unselected serial placed");
  AST_NSS: assert property (
    clk_en && en && sel.sel_low[1] && !sel.ss_mode[1] |=> !func_placed[5])
    else $error("slave select routed in 3-wire");
  AST_SPI: assert property (
    clk_en && en && sel.sel_low[1:0] == 2'b10 && pincfg.mask == '0 &&
    pincfg.drive_pp[0] |=> pin_oe[0] && pin_out[0] == $past(func_out[2]))
    else $error("spi clock not on lowest pin");
  AST_OD: assert property (
    clk_en && en && sel.sel_low == 8'h04 && pincfg.mask == '0 |=>
    pin_out[1:0] == 2'b00 && pin_oe[1:0] == ~$past(func_out[7:6]))
    else $error("i2c pins not open-drain");
  AST_IDLE: assert property (
    clk_en && !en ##1 clk_en && !en |=> func_in == $past(func_idle))
    else $error("unrouted input not idle");
  AST_LATCH: assert property (
    $past(resetn, 3) && $past(clk_en, 1) && $past(clk_en, 2) &&
    $past(clk_en, 3) |-> port_latch_in == $past(pin_in, 3))
    else $error("latch does not follow pin");
endmodule // pxb_crossbar_properties

bind pxb_crossbar pxb_crossbar_properties u_props (.sys_clk, .resetn,
  .clk_en, .sel, .pincfg, .func_out, .func_idle, .pin_in, .pin_out,
  .pin_oe, .port_latch_in, .func_in, .func_placed);

// [sim/tb_pxb_crossbar.sv]
`timescale 1ns/1ps
module tb_pxb_crossbar
  import pxb_pkg::*;
;
  logic        sys_clk, resetn, clk_en;
  pxb_sel_s    sel;
  pxb_pincfg_s pincfg;
  logic [23:0] port_latch_out, pin_in, pin_out, pin_oe, port_latch_in, board;
  logic [21:0] func_out, func_idle, func_in, func_placed;
  int          error_cnt, compares, cyc;
  pxb_crossbar dut (.sys_clk, .resetn, .clk_en, .sel, .pincfg,
    .port_latch_out, .func_out, .func_idle, .pin_in, .pin_out, .pin_oe,
    .port_latch_in, .func_in, .func_placed);
  pxb_pin_model u_board (.pin_out, .pin_oe, .board, .pin_in);
  task automatic chk(input logic [23:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t %s", $time, m);
    end
  endtask
  // hi: [2:0] capture count, [3] ext counter, [4] t0, [5] t1, [6] enable
  task automatic setup(input logic [7:0] lo, hi, input logic [1:0] ss,
                       input logic [23:0] msk);
    @(posedge sys_clk);
    sel <= '{lo, hi, ss};
    pincfg <= '{msk, 24'hFF_FFFF};
    repeat (5) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_off();
    setup(8'hFF, 8'h3E, 2'b10, 24'h00_0000);
    chk(pin_oe, 24'h00_0000, "pins driven while off");
    chk(func_placed, 24'h00_0000, "placed while off");
    $display("test off done");
  endtask
  task automatic t_ser_spi();
    setup(8'h03, 8'h40, 2'b10, 24'h00_0000);
    chk(func_placed, 24'h00_003F, "serial+spi placement");
    chk(pin_out[4], func_out[0], "tx pin");
    chk(pin_out[2:0], func_out[4:2], "spi pins");
    chk(func_in[5:0], func_out[5:0], "routed inputs");
    setup(8'h03, 8'h40, 2'b00, 24'h00_0000);
    chk(func_placed, 24'h00_001F, "nss in 3-wire");
    setup(8'h02, 8'h42, 2'b10, 24'h00_0000);
    chk(func_placed, 24'h00_603C, "spi with two captures");
    chk(pin_out[5:0], {func_out[14:13], func_out[5:2]}, "cex");
    $display("test serial spi done");
  endtask
  task automatic t_skip();
    // oscillator pins excluded in the same write that sets the select bytes, enable already on
    setup(8'hFF, 8'h7E, 2'b10, 24'h00_0300);
    chk(func_placed, 24'h3F_FFFF, "all placed");
    chk(pin_out[20], func_out[18], "capture five with skip");
    setup(8'hFF, 8'h7E, 2'b10, 24'h00_0000);
    chk(pin_out[18], func_out[18], "capture five no skip");
    $display("test skip done");
  endtask
  task automatic t_over();
    setup(8'hFF, 8'h7E, 2'b10, 24'hFF_0000);
    chk(func_placed, 24'h00_FFFF, "leftovers placed");
    chk(func_in[21:16], func_idle[21:16], "leftover input");
    $display("test overflow done");
  endtask
  task automatic t_i2c();
    setup(8'h04, 8'h40, 2'b10, 24'h00_0000);
    chk(func_placed, 24'h00_00C0, "i2c pair");
    chk({pin_oe[1:0], pin_out[1:0]}, {~func_out[7:6], 2'b00}, "od");
    $display("test i2c done");
  endtask
  task automatic t_latch();
    setup(8'h00, 8'h00, 2'b00, 24'h00_0000);
    @(posedge sys_clk);
    board <= 24'hA5_5AC3;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(port_latch_in, 24'hA5_5AC3, "latch level");
    $display("test latch done");
  endtask
  task automatic t_gpio();
    @(posedge sys_clk);
    sel            <= '{8'h00, 8'h40, 2'b00};
    pincfg         <= '{24'h00_0000, 24'h00_FFFF};
    port_latch_out <= 24'h5A_C35A;
    @(posedge sys_clk);
    #1;
    chk(pin_out, 24'h00_C35A, "gpio level");
    chk(pin_oe, 24'hA5_FFFF, "gpio drive mode");
    @(posedge sys_clk);
    clk_en         <= 1'b0;
    port_latch_out <= 24'h00_0000;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(pin_out, 24'h00_C35A, "moved while frozen");
    @(posedge sys_clk);
    clk_en <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk(pin_out, 24'h00_0000, "latch change lost");
    chk(pin_oe, 24'hFF_FFFF, "open-drain low not driven");
    $display("test gpio done");
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ceiling far above the roughly 71 cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    resetn = 0;
    clk_en = 1;
    sel = '0;
    pincfg = '0;
    board = '1;
    port_latch_out = '0;
    func_out = 22'h15_5555;
    func_idle = 22'h2A_AAAA;
    repeat (5) @(posedge sys_clk);
    resetn <= 1;
    t_off();
    t_ser_spi();
    t_skip();
    t_over();
    t_i2c();
    t_gpio();
    t_latch();
    tally_and_finish();
  end
endmodule // tb_pxb_crossbar
